// ### rtl/dsr_load_chan.sv
// One channel's converter register, loaded from pending data on a load.
// Assumes the load strobe is a one-cycle pulse from the pin edge detect.
module dsr_load_chan #(
    parameter int W = 16
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_b,
    // Load control
    input wire logic i_load,
    input wire logic i_mask,
    // Data
    input wire logic [W-1:0] i_pend,
    output logic [W-1:0] o_data_q
);
    // Masked channel keeps its code when the load strobe fires
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_b)
            o_data_q <= '0;
        else if (i_load && !i_mask)
            o_data_q <= i_pend;
    end
endmodule : dsr_load_chan

// ### rtl/dsr_pkg.sv
// Constants and carrier types for the converter status/power/span bank.
// Assumes a front end that turns host serial frames into register requests.
//
// Contract
// - Each implemented error flag stays set until host writes one there.
// - Error flags live at 0x17 and reset to 0x01, reset-done set.
// - Reset-done flag drives alert while set; host clears it after init.
// - Flag bit 6 sets when the reference drops below 2 V.
// - Flag bit 5 sets when a dual-serial stream runs past the map.
// - Flag bit 4 sets when the background checksum finds corruption.
// - Power-down register at 0x18, per channel, resets to zero.
// - Bit 5 sleeps core 1, bit 4 sleeps core 0; one means asleep.
// - Bit 1 sleeps amplifier 1, bit 0 sleeps amplifier 0.
// - Span register 0x19: channel 1 in bits 7:4, channel 0 in 3:0.
// - Span codes 0..4 select 0-2.5, 0-5, 0-10, +-5, -2.5..7.5 V.
// - Load mask at 0x28; clear mask bit lets load pin latch channel.
// - Set mask bit (1 for ch1, 0 for ch0) keeps converter data.
// - Alarm mask register stops matching errors from raising alert; the code gates only bits 6:4, so reset-done alerts even with bit 0 set.
// - Load pin is active low; low pulse moves pending data across.
package dsr_pkg;
    // Register offsets
    localparam logic [7:0] DSR_OFF_ALARM_MASK = 8'h16;
    localparam logic [7:0] DSR_OFF_FLAGS = 8'h17;
    localparam logic [7:0] DSR_OFF_POWER = 8'h18;
    localparam logic [7:0] DSR_OFF_SPAN = 8'h19;
    localparam logic [7:0] DSR_OFF_LOAD_MASK = 8'h28;
    // Error flag layout and reset value
    localparam int DSR_FLAG_RESET_BIT = 0;
    localparam int DSR_FLAG_CRC_BIT = 4;
    localparam int DSR_FLAG_STREAM_BIT = 5;
    localparam int DSR_FLAG_REF_BIT = 6;
    localparam logic [7:0] DSR_FLAGS_RST = 8'h01;
    localparam logic [7:0] DSR_FLAGS_IMPL = 8'h71;
    // Alarm mask layout: bit 0 is stored but left out of the gate, so reset-done is unmasked
    localparam logic [7:0] DSR_ALARM_MASK_IMPL = 8'h7f;
    localparam logic [7:0] DSR_ALARM_MASK_RST = 8'h00;
    localparam logic [7:0] DSR_ALARM_GATED = 8'h70;
    // Power-down layout
    localparam int DSR_AMP0_BIT = 0;
    localparam int DSR_CORE0_BIT = 4;
    localparam logic [7:0] DSR_POWER_IMPL = 8'h33;
    localparam logic [7:0] DSR_POWER_RST = 8'h00;
    // Span layout
    localparam int DSR_SPAN_W = 4;
    localparam int DSR_SPAN0_LSB = 0;
    localparam int DSR_SPAN1_LSB = 4;
    localparam logic [7:0] DSR_SPAN_RST = 8'h00;
    // Span selector codes
    localparam logic [2:0] DSR_SPAN_0_2V5 = 3'h0;
    localparam logic [2:0] DSR_SPAN_0_5V = 3'h1;
    localparam logic [2:0] DSR_SPAN_0_10V = 3'h2;
    localparam logic [2:0] DSR_SPAN_PM5V = 3'h3;
    localparam logic [2:0] DSR_SPAN_N2V5_7V5 = 3'h4;
    // Load mask layout
    localparam logic [7:0] DSR_LOAD_MASK_IMPL = 8'h03;
    localparam logic [7:0] DSR_LOAD_MASK_RST = 8'h00;
    // Data widths
    localparam int DSR_CODE_W = 16;
    localparam int DSR_CHANNELS = 2;

    // Register request from the serial front end
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } dsr_req_t;

    // Error events from the analog and digital monitors
    typedef struct packed {
        logic ref_low;
        logic stream_over;
        logic crc_bad;
    } dsr_evt_t;
endpackage : dsr_pkg

// ### rtl/dsr_regs.sv
// Status, power-down, span and load-mask register bank of the converter.
// Assumes requests arrive decoded from the serial front end, one per cycle,
// and all inputs are synchronous to i_clk.
module dsr_regs #(
    parameter int CODE_W = dsr_pkg::DSR_CODE_W
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_b,
    // Register access
    input wire dsr_pkg::dsr_req_t i_req,
    output logic [7:0] o_rdata_q,
    output logic o_rvalid_q,
    // Monitor events
    input wire dsr_pkg::dsr_evt_t i_evt,
    // Load pin and channel data
    input wire logic i_load_pin_n,
    input wire logic [CODE_W-1:0] i_pend0,
    input wire logic [CODE_W-1:0] i_pend1,
    output logic [CODE_W-1:0] o_conv0_q,
    output logic [CODE_W-1:0] o_conv1_q,
    // Analog controls
    output logic [1:0] o_core_sleep_q,
    output logic [1:0] o_amp_sleep_q,
    output logic [3:0] o_span0_select_q,
    output logic [3:0] o_span1_select_q,
    // Alert
    output logic o_alert_q
);
    import dsr_pkg::*;

    logic [7:0] flags;
    logic [7:0] flag_set;
    logic [7:0] alarm_mask_q;
    logic [7:0] power_q;
    logic [7:0] span_q;
    logic [7:0] load_mask_q;
    logic [7:0] rdata_d;
    logic alert_d;
    logic load_pin_n_q;
    logic load_fire;
    logic wr_flags;
    logic [CODE_W-1:0] conv0;
    logic [CODE_W-1:0] conv1;

    assign wr_flags = i_req.wr && (i_req.addr == DSR_OFF_FLAGS);

    // Hardware events routed to their flag positions
    always_comb
    begin
        flag_set = '0;
        flag_set[DSR_FLAG_REF_BIT] = i_evt.ref_low;
        flag_set[DSR_FLAG_STREAM_BIT] = i_evt.stream_over;
        flag_set[DSR_FLAG_CRC_BIT] = i_evt.crc_bad;
    end

    // One sticky cell per implemented flag, reserved bits tied low
    for (genvar i = 0; i < 8; i++)
    begin : g_flag
        if (DSR_FLAGS_IMPL[i])
        begin : g_cell
            dsr_sticky #(
                .RST_VAL(DSR_FLAGS_RST[i])
            ) u_flag (
                .i_clk(i_clk),
                .i_rst_b(i_rst_b),
                .i_set(flag_set[i]),
                .i_clr(wr_flags && i_req.wdata[i]),
                .o_flag_q(flags[i])
            );
        end
        else
        begin : g_rsvd
            assign flags[i] = 1'b0;
        end
    end

    // Alarm mask register
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_b)
            alarm_mask_q <= DSR_ALARM_MASK_RST;
        else if (i_req.wr && i_req.addr == DSR_OFF_ALARM_MASK)
            alarm_mask_q <= i_req.wdata & DSR_ALARM_MASK_IMPL;
    end

    // Power-down register, reserved bits dropped
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_b)
            power_q <= DSR_POWER_RST;
        else if (i_req.wr && i_req.addr == DSR_OFF_POWER)
            power_q <= i_req.wdata & DSR_POWER_IMPL;
    end

    // Span register
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_b)
            span_q <= DSR_SPAN_RST;
        else if (i_req.wr && i_req.addr == DSR_OFF_SPAN)
            span_q <= i_req.wdata;
    end

    // Load mask register
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_b)
            load_mask_q <= DSR_LOAD_MASK_RST;
        else if (i_req.wr && i_req.addr == DSR_OFF_LOAD_MASK)
            load_mask_q <= i_req.wdata & DSR_LOAD_MASK_IMPL;
    end

    // Falling edge of the active-low load pin gives one load strobe
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_b)
            load_pin_n_q <= 1'b1;
        else
            load_pin_n_q <= i_load_pin_n;
    end
    assign load_fire = load_pin_n_q && !i_load_pin_n;

    // Converter registers for both channels
    dsr_load_chan #(
        .W(CODE_W)
    ) u_chan0 (
        .i_clk(i_clk),
        .i_rst_b(i_rst_b),
        .i_load(load_fire),
        .i_mask(load_mask_q[0]),
        .i_pend(i_pend0),
        .o_data_q(conv0)
    );

    dsr_load_chan #(
        .W(CODE_W)
    ) u_chan1 (
        .i_clk(i_clk),
        .i_rst_b(i_rst_b),
        .i_load(load_fire),
        .i_mask(load_mask_q[1]),
        .i_pend(i_pend1),
        .o_data_q(conv1)
    );

    // Analog controls come straight from register flops
    assign o_conv0_q = conv0;
    assign o_conv1_q = conv1;
    assign o_core_sleep_q = power_q[DSR_CORE0_BIT +: 2];
    assign o_amp_sleep_q = power_q[DSR_AMP0_BIT +: 2];
    assign o_span0_select_q = span_q[DSR_SPAN0_LSB +: DSR_SPAN_W];
    assign o_span1_select_q = span_q[DSR_SPAN1_LSB +: DSR_SPAN_W];

    // Alert: any flag set and not masked; reset-done cannot be masked
    assign alert_d =
        |(flags & ~(alarm_mask_q & DSR_ALARM_GATED));

    always_ff @(posedge i_clk)
    begin
        if (!i_rst_b)
            o_alert_q <= 1'b0;
        else
            o_alert_q <= alert_d;
    end

    // Read mux, unmapped offsets read zero
    always_comb
    begin
        case (i_req.addr)
            DSR_OFF_ALARM_MASK: rdata_d = alarm_mask_q;
            DSR_OFF_FLAGS: rdata_d = flags;
            DSR_OFF_POWER: rdata_d = power_q;
            DSR_OFF_SPAN: rdata_d = span_q;
            DSR_OFF_LOAD_MASK: rdata_d = load_mask_q;
            default: rdata_d = 8'h00;
        endcase
    end

    // Read data held until the next read, valid for one cycle
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_b)
        begin
            o_rdata_q <= 8'h00;
            o_rvalid_q <= 1'b0;
        end
        else
        begin
            o_rvalid_q <= i_req.rd;
            if (i_req.rd)
                o_rdata_q <= rdata_d;
        end
    end

    // Checks
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);

    property p_flag_hold;
        flags[DSR_FLAG_REF_BIT] && !wr_flags |=>
            flags[DSR_FLAG_REF_BIT];
    endproperty
    a_flag_hold: assert property (p_flag_hold)
        else $error("flag lost without a clear");

    property p_flag_clear;
        wr_flags && i_req.wdata[DSR_FLAG_CRC_BIT] && !i_evt.crc_bad |=>
            !flags[DSR_FLAG_CRC_BIT];
    endproperty
    a_flag_clear: assert property (p_flag_clear)
        else $error("write of one did not clear flag");

    property p_flags_reset;
        $past(!i_rst_b) |-> flags == DSR_FLAGS_RST && power_q == 8'h00;
    endproperty
    a_flags_reset: assert property (p_flags_reset)
        else $error("wrong value after reset");

    property p_reset_alert;
        flags[DSR_FLAG_RESET_BIT] |=> o_alert_q;
    endproperty
    a_reset_alert: assert property (p_reset_alert)
        else $error("reset-done flag not alerting");

    property p_events;
        i_evt.ref_low ##0 i_evt.stream_over ##0 i_evt.crc_bad |=>
            (flags & DSR_ALARM_GATED) == DSR_ALARM_GATED;
    endproperty
    a_events: assert property (p_events)
        else $error("event did not set its flag");

    property p_ref_set;
        i_evt.ref_low ##1 !(wr_flags && i_req.wdata[DSR_FLAG_REF_BIT])
            |-> flags[DSR_FLAG_REF_BIT] [*2];
    endproperty
    a_ref_set: assert property (p_ref_set)
        else $error("reference flag not set");

    property p_power;
        i_req.wr && i_req.addr == DSR_OFF_POWER |=>
            o_core_sleep_q == $past(i_req.wdata[5:4]) &&
            o_amp_sleep_q == $past(i_req.wdata[1:0]) &&
            power_q[7:6] == 2'h0;
    endproperty
    a_power: assert property (p_power)
        else $error("power-down fields wrong");

    property p_span;
        i_req.wr && i_req.addr == DSR_OFF_SPAN |=>
            {o_span1_select_q, o_span0_select_q} == $past(i_req.wdata);
    endproperty
    a_span: assert property (p_span)
        else $error("span fields wrong");

    property p_load;
        load_fire && !load_mask_q[0] |=> conv0 == $past(i_pend0);
    endproperty
    a_load: assert property (p_load)
        else $error("unmasked channel not loaded");

    property p_masked;
        load_fire && load_mask_q[1] |=> $stable(conv1);
    endproperty
    a_masked: assert property (p_masked)
        else $error("masked channel changed");

    property p_alarm_mask;
        flags != 8'h00 && (flags & ~DSR_ALARM_GATED) == 8'h00 &&
            (alarm_mask_q & DSR_ALARM_GATED) == DSR_ALARM_GATED
            |=> !o_alert_q;
    endproperty
    a_alarm_mask: assert property (p_alarm_mask)
        else $error("masked error raised alert");

    property p_read;
        i_req.rd |=> o_rvalid_q && o_rdata_q == $past(rdata_d);
    endproperty
    a_read: assert property (p_read)
        else $error("read answer wrong");

    property p_load1;
        load_fire && !load_mask_q[1] |=> conv1 == $past(i_pend1);
    endproperty
    a_load1: assert property (p_load1)
        else $error("unmasked channel 1 not loaded");

    property p_conv_still;
        !load_fire |=> $stable(conv0) && $stable(conv1);
    endproperty
    a_conv_still: assert property (p_conv_still)
        else $error("converter code changed without a load");

    property p_rsvd;
        (flags & ~DSR_FLAGS_IMPL) == 8'h00 &&
            (power_q & ~DSR_POWER_IMPL) == 8'h00 &&
            (load_mask_q & ~DSR_LOAD_MASK_IMPL) == 8'h00;
    endproperty
    a_rsvd: assert property (p_rsvd)
        else $error("reserved bit set");

    property p_rvalid_pulse;
        !i_req.rd |=> !o_rvalid_q;
    endproperty
    a_rvalid_pulse: assert property (p_rvalid_pulse)
        else $error("read answer without a read");

    c_clear_reset: cover property (
        wr_flags && i_req.wdata[DSR_FLAG_RESET_BIT] ##2 !o_alert_q);
    c_load_both: cover property (
        load_fire && load_mask_q == 8'h00);
    c_span_code: cover property (
        o_span0_select_q[2:0] == DSR_SPAN_N2V5_7V5);
    c_set_clear: cover property (
        wr_flags && i_req.wdata[DSR_FLAG_REF_BIT] && i_evt.ref_low);
endmodule : dsr_regs

// ### rtl/dsr_sticky.sv
// One sticky error flag, set by hardware, cleared by a write of one.
// Assumes set and clear are synchronous single-clock signals.
module dsr_sticky #(
    parameter logic RST_VAL = 1'b0
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_b,
    // Set and clear
    input wire logic i_set,
    input wire logic i_clr,
    // Flag
    output logic o_flag_q
);
    // Set wins over a clear in the same cycle so no event is lost
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_b)
            o_flag_q <= RST_VAL;
        else if (i_set)
            o_flag_q <= 1'b1;
        else if (i_clr)
            o_flag_q <= 1'b0;
    end
endmodule : dsr_sticky

// ### sim/dsr_host.sv
// Host model that issues decoded register requests to the bank.
// Assumes the bank answers a read with rvalid one cycle after the request.
module dsr_host
    import dsr_pkg::*;
(
    // Clock
    input wire logic i_clk,
    // Request and answer
    output dsr_pkg::dsr_req_t o_req,
    input wire logic [7:0] i_rdata_q,
    input wire logic i_rvalid_q
);
    timeunit 1ns;
    timeprecision 100ps;

    // Idle request at time zero
    initial o_req = '0;

    // One-cycle write, then one idle edge so the next request starts clean
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        o_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge i_clk);
        o_req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
        @(posedge i_clk);
    endtask : wr

    // One-cycle read; answer taken at the following edge
    task automatic rd(input logic [7:0] a, output logic [7:0] d,
                      output logic v);
        o_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h5a};
        @(posedge i_clk);
        o_req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'ha5};
        @(posedge i_clk);
        v = i_rvalid_q;
        d = i_rdata_q;
    endtask : rd
endmodule : dsr_host

// ### sim/tb_top.sv
// Testbench for the status, power, span and load-mask bank.
// Assumes the host model drives the register port of the bank.
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import dsr_pkg::*;

    logic clk, rst_b, pin_n, rvalid, alert;
    dsr_req_t req;
    dsr_evt_t evt;
    logic [15:0] pend0, pend1, conv0, conv1, exp0, exp1;
    logic [7:0] rdata, w;
    logic [1:0] core, amp;
    logic [3:0] sp0, sp1;
    logic [7:0] pw [5] = '{8'hff, 8'h10, 8'h02, 8'h20, 8'h01};
    int failures = 0;
    int samples_checked = 0;

    dsr_host u_host (.i_clk(clk), .o_req(req), .i_rdata_q(rdata),
                     .i_rvalid_q(rvalid));

    dsr_regs u_dut (.i_clk(clk), .i_rst_b(rst_b), .i_req(req),
        .o_rdata_q(rdata), .o_rvalid_q(rvalid), .i_evt(evt),
        .i_load_pin_n(pin_n), .i_pend0(pend0), .i_pend1(pend1),
        .o_conv0_q(conv0), .o_conv1_q(conv1), .o_core_sleep_q(core),
        .o_amp_sleep_q(amp), .o_span0_select_q(sp0),
        .o_span1_select_q(sp1), .o_alert_q(alert));

    // Compare register-sized values
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            failures++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk8

    // Compare converter codes
    task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            failures++;
            $display("ERROR %0t: code %h expected %h", $time, got, exp);
        end
    endtask : chk16

    // Read a register and check answer pulse and data
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        logic v;
        u_host.rd(a, d, v);
        chk8({7'h00, v}, 8'h01);
        chk8(d, e);
    endtask : rd_chk

    // Print counts and verdict, then stop
    task automatic final_report;
        $display("checks %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : final_report

    // 200 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // Watchdog against a hung sequence
    initial
    begin
        #20000;
        failures++;
        final_report();
    end

    // Main sequence
    initial
    begin
        rst_b = 1'b0;
        evt = '0;
        pin_n = 1'b1;
        pend0 = 16'h0000;
        pend1 = 16'h0000;
        exp0 = 16'h0000;
        exp1 = 16'h0000;
        repeat (12) @(posedge clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge clk);
        chk8({7'h00, alert}, 8'h01);
        chk8({2'b00, core, 2'b00, amp}, 8'h00);
        chk8({sp1, sp0}, 8'h00);
        chk16(conv0 | conv1, 16'h0000);
        rd_chk(8'h17, 8'h01);
        rd_chk(8'h16, 8'h00);
        rd_chk(8'h18, 8'h00);
        rd_chk(8'h19, 8'h00);
        rd_chk(8'h28, 8'h00);
        // Host releases the alert after init
        u_host.wr(8'h17, 8'h01);
        repeat (2) @(posedge clk);
        chk8({7'h00, alert}, 8'h00);
        rd_chk(8'h17, 8'h00);
        u_host.wr(8'h20, 8'hff);
        rd_chk(8'h20, 8'h00);
        // Each monitor event sets its flag, held against other clears
        for (int i = 0; i < 3; i++)
        begin
            evt <= dsr_evt_t'(3'(1 << i));
            @(posedge clk);
            evt <= '0;
            repeat (2) @(posedge clk);
            chk8({7'h00, alert}, 8'h01);
            u_host.wr(8'h17, ~(8'h10 << i));
            rd_chk(8'h17, 8'h10 << i);
            u_host.wr(8'h17, 8'h10 << i);
            repeat (2) @(posedge clk);
            chk8({7'h00, alert}, 8'h00);
            rd_chk(8'h17, 8'h00);
        end
        // Masked flags stay silent until unmasked
        u_host.wr(8'h16, 8'hff);
        rd_chk(8'h16, 8'h7f);
        evt <= 3'b111;
        @(posedge clk);
        evt <= '0;
        repeat (2) @(posedge clk);
        chk8({7'h00, alert}, 8'h00);
        rd_chk(8'h17, 8'h70);
        u_host.wr(8'h16, 8'h00);
        repeat (2) @(posedge clk);
        chk8({7'h00, alert}, 8'h01);
        u_host.wr(8'h17, 8'hff);
        repeat (2) @(posedge clk);
        chk8({7'h00, alert}, 8'h00);
        // Power-down bits per channel
        for (int i = 0; i < 5; i++)
        begin
            w = pw[i];
            u_host.wr(8'h18, w);
            @(posedge clk);
            chk8({2'b00, core, 2'b00, amp}, w & 8'h33);
            rd_chk(8'h18, w & 8'h33);
        end
        // Every span code on both channels
        for (int i = 0; i < 5; i++)
        begin
            w = {4'(i), 4'(4 - i)};
            u_host.wr(8'h19, w);
            @(posedge clk);
            chk8({sp1, sp0}, w);
            rd_chk(8'h19, w);
        end
        // Load pin under every mask setting; held low loads once
        for (int i = 0; i < 4; i++)
        begin
            u_host.wr(8'h28, {6'h3f, 2'(i)});
            rd_chk(8'h28, {6'h00, 2'(i)});
            pend0 <= 16'h1000 + 16'(i);
            pend1 <= 16'h2000 + 16'(i);
            pin_n <= 1'b0;
            @(posedge clk);
            exp0 = i[0] ? exp0 : 16'h1000 + 16'(i);
            exp1 = i[1] ? exp1 : 16'h2000 + 16'(i);
            pend0 <= 16'hdead;
            pend1 <= 16'hbeef;
            @(posedge clk);
            chk16(conv0, exp0);
            chk16(conv1, exp1);
            repeat (2) @(posedge clk);
            chk16(conv0, exp0);
            chk16(conv1, exp1);
            pin_n <= 1'b1;
            @(posedge clk);
        end
        // Reset in mid-run restores flags, power-down, load mask and converter codes
        rst_b <= 1'b0;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge clk);
        chk8({7'h00, alert}, 8'h01);
        chk8({2'b00, core, 2'b00, amp}, 8'h00);
        chk16(conv0 | conv1, 16'h0000);
        rd_chk(8'h17, 8'h01);
        rd_chk(8'h28, 8'h00);
        final_report();
    end
endmodule : tb_top
